// file: logic/serial_channel_b.sv
/*
  Serial channel B: AHB-Lite register slave, receiver with single
  buffer stage, status flags, fixed-format transmitter.
  Assumes one 200 MHz clock; rxd and sclk_i are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_map.svh"
// Contract
// - parity sense: 0 odd, 1 even
// - receive enable bit 7 gates reception
// - buffer read gives rx, write loads tx
// - completion copies shift to buffer, flags ready
// - ignored multiprocessor frame changes nothing
// - separate hidden shift registers, one buffer
// - low four error bits sticky until cleared
// - unread buffer sets overrun again next frame
// - stop bit zero sets framing error
// - overrun when previous data unread, still load
// - parity mismatch sets parity error
// - address marker while data-waiting sets error
// - bit 4 enables receive-ready request
// - bit 5 set on receive ready, sw clears
// - bit 6 enables transmit-ready request
// - bit 7 set on transmit ready, sw clears
// - reset zeroes status, buffer undefined
// - control bit 2 selects data or address wait
// - control bit 5 enables parity bit
// - bit 4 master or slave, synchronous only
module serial_channel_b #(
  parameter int TICK_DIV = `TICK_DIV_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        rxd,
  output var  logic        txd,
  input  wire logic        sclk_i,
  output var  logic        sclk_o,
  output var  logic        sclk_oe,
  output var  logic        rx_irq,
  output var  logic        tx_irq
);
  localparam int DW = $clog2(TICK_DIV);

  // Divider needs at least two states to make a one-cycle tick
  if (TICK_DIV < 2) begin : g_div_check
    $error("TICK_DIV must be at least 2");
  end

  serial_channel_pkg::rx_ctrl_t     ctrl_ff;
  serial_channel_pkg::line_status_t status_ff;
  serial_channel_pkg::line_status_t nxt_status;
  serial_channel_pkg::rx_state_t    rx_state_ff;
  serial_channel_pkg::tx_state_t    tx_state_ff;

  logic [DW-1:0] div_ff;
  logic          tick_ff;
  logic          aph_ff;
  logic          wr_ff;
  logic [7:0]    addr_ff;
  logic [31:0]   hrdata_ff;
  logic          hreadyout_ff;
  logic          rxd_s1_ff;
  logic          rxd_s2_ff;
  logic          rxd_s3_ff;
  logic          sclk_s1_ff;
  logic          sclk_s2_ff;
  logic          sclk_s3_ff;
  logic          sclk_o_ff;
  logic          sclk_oe_ff;
  logic [3:0]    sclk_cnt_ff;
  logic [3:0]    ocnt_ff;
  logic [3:0]    bidx_ff;
  logic [7:0]    rx_shift_ff;
  logic          par_ff;
  logic          mpc_ff;
  logic [7:0]    rx_buf_ff;
  logic          unread_ff;
  logic [7:0]    tx_buf_ff;
  logic          tx_full_ff;
  logic [9:0]    tx_sh_ff;
  logic [3:0]    tx_cnt_ff;
  logic [3:0]    tx_bit_ff;
  logic          txd_ff;
  logic          rx_irq_ff;
  logic          tx_irq_ff;

  logic       acc;
  logic       wr_now;
  logic       rd_now;
  logic       wr_ctrl;
  logic       wr_buf;
  logic       wr_stat;
  logic       rd_buf;
  logic [7:0] rd_mux;
  logic       sync_mode;
  logic       mp_mode;
  logic       master_rise;
  logic       sbit;
  logic       bit_ev;
  logic [3:0] nbits;
  logic       rx_done;
  logic       fe_now;
  logic       perr_now;
  logic       merr_now;
  logic       ignored;
  logic       load;
  logic       tx_ev;

  // Bus slave: one wait state so reads see writes of the prior transfer
  assign acc     = hsel && htrans[1] && hready;
  assign wr_now  = aph_ff && wr_ff;
  assign rd_now  = aph_ff && !wr_ff;
  assign wr_ctrl = wr_now && (addr_ff[7:2] == 6'(`RX_CTRL_OFS >> 2));
  assign wr_buf  = wr_now && (addr_ff[7:2] == 6'(`DATA_BUF_OFS >> 2));
  assign wr_stat = wr_now && (addr_ff[7:2] == 6'(`STATUS_OFS >> 2));
  assign rd_buf  = rd_now && (addr_ff[7:2] == 6'(`DATA_BUF_OFS >> 2));

  always_comb begin
    unique case (addr_ff[7:2])
      6'(`RX_CTRL_OFS >> 2):  rd_mux = ctrl_ff;
      6'(`DATA_BUF_OFS >> 2): rd_mux = rx_buf_ff;
      6'(`STATUS_OFS >> 2):   rd_mux = status_ff;
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff       <= 1'b0;
      wr_ff        <= 1'b0;
      addr_ff      <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= 32'h0000_0000;
    end else if (acc) begin
      aph_ff       <= 1'b1;
      wr_ff        <= hwrite;
      addr_ff      <= haddr[7:0];
      hreadyout_ff <= 1'b0;
    end else if (aph_ff) begin
      aph_ff       <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= rd_now ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `RX_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= hwdata[7:0] | `RX_CTRL_FIXED;
    end
  end

  // Oversample tick, sixteen per bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == DW'(TICK_DIV - 1));
      div_ff  <= (div_ff == DW'(TICK_DIV - 1)) ? '0 : div_ff + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_s1_ff  <= 1'b1;
      rxd_s2_ff  <= 1'b1;
      rxd_s3_ff  <= 1'b1;
      sclk_s1_ff <= 1'b1;
      sclk_s2_ff <= 1'b1;
      sclk_s3_ff <= 1'b1;
    end else begin
      rxd_s1_ff  <= rxd;
      rxd_s2_ff  <= rxd_s1_ff;
      rxd_s3_ff  <= rxd_s2_ff;
      sclk_s1_ff <= sclk_i;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
    end
  end

  assign sync_mode = ctrl_ff.mode[`MODE_SYNC_BIT];
  assign mp_mode   = ctrl_ff.mode[`MODE_MP_BIT];
  assign nbits     = `DATA_BITS + 4'(ctrl_ff.rx_parity_enable)
                   + 4'(mp_mode);

  // Master drives the shift clock; slave follows the pin's rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_cnt_ff <= 4'h0;
      sclk_o_ff   <= 1'b1;
      sclk_oe_ff  <= 1'b0;
    end else begin
      sclk_oe_ff <= sync_mode && ctrl_ff.rx_master_select
                    && ctrl_ff.rx_enable_bit;
      if (!sclk_oe_ff) begin
        sclk_cnt_ff <= 4'h0;
        sclk_o_ff   <= 1'b1;
      end else if (tick_ff) begin
        sclk_cnt_ff <= (sclk_cnt_ff == `OVS_HALF) ? 4'h0 : sclk_cnt_ff + 4'h1;
        if (sclk_cnt_ff == `OVS_HALF) sclk_o_ff <= !sclk_o_ff;
      end
    end
  end

  assign master_rise = tick_ff && sclk_oe_ff && !sclk_o_ff
                       && (sclk_cnt_ff == `OVS_HALF);
  assign sbit   = ctrl_ff.rx_master_select ? master_rise
                  : (sclk_s2_ff && !sclk_s3_ff);
  assign bit_ev = sync_mode ? sbit : (tick_ff && ocnt_ff == `OVS_LAST);

  // Receiver: data LSB first, then parity, then address marker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_ff <= serial_channel_pkg::RX_IDLE;
      ocnt_ff     <= 4'h0;
      bidx_ff     <= 4'h0;
      rx_shift_ff <= 8'h00;
      par_ff      <= 1'b0;
      mpc_ff      <= 1'b0;
    end else if (!ctrl_ff.rx_enable_bit) begin
      rx_state_ff <= serial_channel_pkg::RX_IDLE;
    end else begin
      if (tick_ff) ocnt_ff <= ocnt_ff + 4'h1;
      unique case (rx_state_ff)
        serial_channel_pkg::RX_IDLE: begin
          bidx_ff <= 4'h0;
          mpc_ff  <= 1'b0;
          ocnt_ff <= 4'h0;
          if (sync_mode) rx_state_ff <= serial_channel_pkg::RX_BITS;
          // Falling edge only: a low stop bit must not restart a frame
          else if (!rxd_s2_ff && rxd_s3_ff)
            rx_state_ff <= serial_channel_pkg::RX_START;
        end
        serial_channel_pkg::RX_START: begin
          if (tick_ff && ocnt_ff == `OVS_HALF) begin
            ocnt_ff     <= 4'h0;
            rx_state_ff <= rxd_s2_ff ? serial_channel_pkg::RX_IDLE
                                     : serial_channel_pkg::RX_BITS;
          end
        end
        serial_channel_pkg::RX_BITS: begin
          if (bit_ev) begin
            if (bidx_ff < `DATA_BITS)
              rx_shift_ff <= {rxd_s2_ff, rx_shift_ff[7:1]};
            else if (ctrl_ff.rx_parity_enable && bidx_ff == `DATA_BITS)
              par_ff <= rxd_s2_ff;
            else
              mpc_ff <= rxd_s2_ff;
            bidx_ff <= bidx_ff + 4'h1;
            if (bidx_ff == nbits - 4'h1)
              rx_state_ff <= serial_channel_pkg::RX_STOP;
          end
        end
        serial_channel_pkg::RX_STOP: begin
          if (sync_mode || bit_ev)
            rx_state_ff <= serial_channel_pkg::RX_IDLE;
        end
      endcase
    end
  end

  assign rx_done  = ctrl_ff.rx_enable_bit
                    && rx_state_ff == serial_channel_pkg::RX_STOP
                    && (sync_mode || bit_ev);
  assign fe_now   = !sync_mode && !rxd_s2_ff;
  assign perr_now = ctrl_ff.rx_parity_enable
                    && ((^rx_shift_ff ^ par_ff)
                        == ctrl_ff.rx_parity_even_select);
  assign ignored  = mp_mode && ctrl_ff.rx_address_wait_select
                    && !mpc_ff;
  assign merr_now = mp_mode && !ctrl_ff.rx_address_wait_select && mpc_ff;
  assign load     = rx_done && !ignored;

  // Buffer holds until the next load; contents undefined after reset
  always_ff @(posedge hclk) begin
    if (load) rx_buf_ff <= rx_shift_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unread_ff <= 1'b0;
    end else if (load) begin
      unread_ff <= 1'b1;
    end else if (rd_buf) begin
      unread_ff <= 1'b0;
    end
  end

  // Flags: write 0 clears, write 1 keeps; a set in the same cycle wins
  always_comb begin
    nxt_status = status_ff;
    if (wr_stat)
      nxt_status = (status_ff & hwdata[7:0] & `ST_FLAG_MASK)
                   | (hwdata[7:0] & `ST_IE_MASK);
    if (load) begin
      nxt_status.framing_error_flag   = nxt_status.framing_error_flag | fe_now;
      nxt_status.overrun_error_flag   = nxt_status.overrun_error_flag
                                        | unread_ff;
      nxt_status.parity_error_flag    = nxt_status.parity_error_flag | perr_now;
      nxt_status.multiproc_error_flag = nxt_status.multiproc_error_flag
                                        | merr_now;
      nxt_status.rx_ready_irq_flag    = 1'b1;
    end
    if (tx_ev) nxt_status.tx_ready_irq_flag = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= `STATUS_RST;
      rx_irq_ff <= 1'b0;
      tx_irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      rx_irq_ff <= status_ff.rx_ready_irq_flag
                   && status_ff.rx_ready_irq_enable;
      tx_irq_ff <= status_ff.tx_ready_irq_flag
                   && status_ff.tx_ready_irq_enable;
    end
  end

  // Transmitter: 8 data bits, one stop, no parity
  assign tx_ev = tx_full_ff && tx_state_ff == serial_channel_pkg::TX_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf_ff   <= 8'h00;
      tx_full_ff  <= 1'b0;
      tx_state_ff <= serial_channel_pkg::TX_IDLE;
      tx_sh_ff    <= 10'h3FF;
      tx_cnt_ff   <= 4'h0;
      tx_bit_ff   <= 4'h0;
      txd_ff      <= 1'b1;
    end else begin
      if (wr_buf) tx_buf_ff <= hwdata[7:0];
      if (wr_buf) tx_full_ff <= 1'b1;
      else if (tx_ev) tx_full_ff <= 1'b0;
      unique case (tx_state_ff)
        serial_channel_pkg::TX_IDLE: begin
          txd_ff <= 1'b1;
          if (tx_ev) begin
            tx_sh_ff    <= {1'b1, tx_buf_ff, 1'b0};
            tx_cnt_ff   <= 4'h0;
            tx_bit_ff   <= 4'h0;
            tx_state_ff <= serial_channel_pkg::TX_SHIFT;
          end
        end
        serial_channel_pkg::TX_SHIFT: begin
          txd_ff <= tx_sh_ff[0];
          if (tick_ff) begin
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == `OVS_LAST) begin
              tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
              tx_bit_ff <= tx_bit_ff + 4'h1;
              if (tx_bit_ff == `TX_FRAME_LAST)
                tx_state_ff <= serial_channel_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = 1'b0;
  assign txd       = txd_ff;
  assign sclk_o    = sclk_o_ff;
  assign sclk_oe   = sclk_oe_ff;
  assign rx_irq    = rx_irq_ff;
  assign tx_irq    = tx_irq_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_addr_taken;
    acc;
  endsequence
  sequence s_wait_then_ready;
    !hreadyout_ff ##1 hreadyout_ff;
  endsequence
  property p_bus_one_wait;
    s_addr_taken |=> s_wait_then_ready;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait)
    else $error("bus transfer not answered after one wait");

  property p_load_copies;
    load |=> rx_buf_ff == $past(rx_shift_ff) && status_ff.rx_ready_irq_flag;
  endproperty
  a_load_copies: assert property (p_load_copies)
    else $error("completion did not load buffer and flag");

  property p_ignored_frame;
    rx_done && ignored && !wr_stat |=> $stable(rx_buf_ff)
      && status_ff.rx_ready_irq_flag == $past(status_ff.rx_ready_irq_flag);
  endproperty
  a_ignored_frame: assert property (p_ignored_frame)
    else $error("ignored frame changed buffer or flag");

  property p_errors_sticky;
    (status_ff[3:0] != 4'h0) && !wr_stat
      |=> (status_ff[3:0] & $past(status_ff[3:0])) == $past(status_ff[3:0]);
  endproperty
  a_errors_sticky: assert property (p_errors_sticky)
    else $error("error flag dropped without software write");

  property p_framing;
    load && fe_now |=> status_ff.framing_error_flag;
  endproperty
  a_framing: assert property (p_framing)
    else $error("stop bit low did not set framing error");

  property p_overrun;
    load && unread_ff |=> status_ff.overrun_error_flag && unread_ff;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("unread buffer did not set overrun");

  property p_parity;
    load && perr_now |=> status_ff.parity_error_flag;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity mismatch not flagged");

  property p_multiproc;
    load && merr_now |=> status_ff.multiproc_error_flag;
  endproperty
  a_multiproc: assert property (p_multiproc)
    else $error("address marker in data wait not flagged");

  property p_rx_disabled;
    !ctrl_ff.rx_enable_bit |=> rx_state_ff == serial_channel_pkg::RX_IDLE
      && !rx_done;
  endproperty
  a_rx_disabled: assert property (p_rx_disabled)
    else $error("receiver ran while disabled");

  property p_tx_ready;
    tx_ev |=> status_ff.tx_ready_irq_flag && !tx_full_ff || $past(wr_buf);
  endproperty
  a_tx_ready: assert property (p_tx_ready)
    else $error("transmit ready not flagged");

  property p_rx_irq;
    (status_ff.rx_ready_irq_flag && status_ff.rx_ready_irq_enable)[*2]
      |-> rx_irq_ff;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive request missing");

endmodule
`default_nettype wire

// file: logic/serial_channel_map.svh
/*
  Register offsets, field positions, reset values and timing counts
  of serial channel B. Assumes a 32-bit AHB-Lite register window.
*/
`ifndef SERIAL_CHANNEL_MAP_SVH
`define SERIAL_CHANNEL_MAP_SVH
`define RX_CTRL_OFS   8'h00
`define DATA_BUF_OFS  8'h04
`define STATUS_OFS    8'h08
`define RX_CTRL_RST   8'h08
`define RX_CTRL_FIXED 8'h08
`define STATUS_RST    8'h00
`define ST_IE_MASK    8'h50
`define ST_FLAG_MASK  8'hAF
`define MODE_MP_BIT   0
`define MODE_SYNC_BIT 1
`define TICK_DIV_DEF  16
`define OVS_LAST      4'hF
`define OVS_HALF      4'h7
`define DATA_BITS     4'h8
`define TX_FRAME_LAST 4'h9
`endif

// file: logic/serial_channel_pkg.sv
/*
  Types of serial channel B: control and status layouts, state codes.
  Assumes the map header supplies every number except the state codes.
*/
package serial_channel_pkg;
  typedef struct packed {
    logic       rx_enable_bit;
    logic       rx_parity_even_select;
    logic       rx_parity_enable;
    logic       rx_master_select;
    logic       fixed_one;
    logic       rx_address_wait_select;
    logic [1:0] mode;
  } rx_ctrl_t;
  typedef struct packed {
    logic tx_ready_irq_flag;
    logic tx_ready_irq_enable;
    logic rx_ready_irq_flag;
    logic rx_ready_irq_enable;
    logic multiproc_error_flag;
    logic parity_error_flag;
    logic overrun_error_flag;
    logic framing_error_flag;
  } line_status_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;
  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;
endpackage

// file: sim/remote_serial_end.sv
/*
  Behavioural far end of serial channel B: sends UART frames on rxd
  and captures bytes from txd. Assumes hclk is the design clock and
  one bit lasts BIT_CYC cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_serial_end #(
  parameter int BIT_CYC = 32
) (
  input  wire logic hclk,
  input  wire logic txd,
  output var  logic rxd
);
  // Line rests at the mark level between frames
  initial rxd = 1'b1;

  task automatic hold_bits(input logic v, input int n);
    rxd <= v;
    repeat (n * BIT_CYC) @(posedge hclk);
  endtask

  // Extra bits: parity first, then address marker, as nx asks
  task automatic send(input logic [7:0] d, input int nx,
                      input logic [1:0] xb, input logic stop);
    hold_bits(1'b0, 1);
    for (int i = 0; i < 8; i++) hold_bits(d[i], 1);
    for (int i = 0; i < nx; i++) hold_bits(xb[i], 1);
    hold_bits(stop, 1);
    hold_bits(1'b1, 2);
  endtask

  // Samples mid-bit; gives up on a silent line after 40 bit times
  task automatic recv(output logic [7:0] d);
    int n;
    n = 0;
    d = 8'h00;
    while (txd !== 1'b0 && n < 40 * BIT_CYC) begin
      @(posedge hclk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge hclk);
      d[i] = txd;
    end
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
/*
  Self-checking bench of serial channel B over AHB-Lite.
  Assumes the map header and a far-end model driving rxd.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_map.svh"
module tb_top;
  localparam int TDIV = 2;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        rxd, txd, sclk_o, sclk_oe, rx_irq, tx_irq;
  int          bad_count, samples_checked;

  serial_channel_b #(.TICK_DIV(TDIV)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxd(rxd), .txd(txd), .sclk_i(1'b1),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .rx_irq(rx_irq), .tx_irq(tx_irq));
  remote_serial_end #(.BIT_CYC(16 * TDIV)) i_far (
    .hclk(hclk), .txd(txd), .rxd(rxd));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t pin %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Holds each phase until hready is sampled high at an edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(x, {24'h000000, exp}, what);
  endtask

  // Receiver is switched off before any other control change
  task automatic set_ctrl(input logic [7:0] v);
    wr(`RX_CTRL_OFS, 8'h08);
    wr(`RX_CTRL_OFS, v);
  endtask

  task automatic t_reset;
    rdchk(`STATUS_OFS, `STATUS_RST, "status at reset");
    rdchk(`RX_CTRL_OFS, `RX_CTRL_RST, "control at reset");
    wr(8'h0C, 8'h5A);
    rdchk(8'h0C, 8'h00, "unmapped word");
    chk_pin(rx_irq, 1'b0, "rx_irq at reset");
  endtask

  task automatic t_basic;
    set_ctrl(8'h88);
    i_far.send(8'hA5, 0, 2'b00, 1'b1);
    chk_pin(rx_irq, 1'b0, "rx_irq masked");
    rdchk(`STATUS_OFS, 8'h20, "rx ready flag");
    wr(`STATUS_OFS, 8'h30);
    repeat (2) @(posedge hclk);
    chk_pin(rx_irq, 1'b1, "rx_irq enabled");
    rdchk(`DATA_BUF_OFS, 8'hA5, "rx byte");
    rdchk(`STATUS_OFS, 8'h30, "flag kept after service");
    wr(`STATUS_OFS, 8'h10);
    rdchk(`STATUS_OFS, 8'h10, "flag cleared");
    chk_pin(rx_irq, 1'b0, "rx_irq after clear");
  endtask

  task automatic t_disabled;
    set_ctrl(8'h08);
    i_far.send(8'h3C, 0, 2'b00, 1'b1);
    rdchk(`STATUS_OFS, 8'h10, "no event while off");
    rdchk(`DATA_BUF_OFS, 8'hA5, "buffer held");
  endtask

  task automatic t_parity;
    for (int s = 0; s < 2; s++) begin
      set_ctrl(8'hA8 | (s[0] ? 8'h40 : 8'h00));
      i_far.send(8'h0F, 1, {1'b0, ~s[0]}, 1'b1);
      rdchk(`DATA_BUF_OFS, 8'h0F, "parity frame");
      rdchk(`STATUS_OFS, 8'h30, "good parity");
      i_far.send(8'h0F, 1, {1'b0, s[0]}, 1'b1);
      rdchk(`STATUS_OFS, 8'h34, "bad parity");
      rdchk(`DATA_BUF_OFS, 8'h0F, "bad parity data");
      i_far.send(8'h0F, 1, {1'b0, ~s[0]}, 1'b1);
      rdchk(`STATUS_OFS, 8'h34, "parity sticky");
      rdchk(`DATA_BUF_OFS, 8'h0F, "good again");
      wr(`STATUS_OFS, 8'h10);
    end
  endtask

  task automatic t_framing;
    set_ctrl(8'h88);
    i_far.send(8'h55, 0, 2'b00, 1'b0);
    rdchk(`STATUS_OFS, 8'h31, "stop bit low");
    rdchk(`DATA_BUF_OFS, 8'h55, "framing data");
    i_far.send(8'h66, 0, 2'b00, 1'b1);
    rdchk(`STATUS_OFS, 8'h31, "framing sticky");
    rdchk(`DATA_BUF_OFS, 8'h66, "next data");
    wr(`STATUS_OFS, 8'h10);
  endtask

  task automatic t_overrun;
    i_far.send(8'h11, 0, 2'b00, 1'b1);
    i_far.send(8'h22, 0, 2'b00, 1'b1);
    rdchk(`STATUS_OFS, 8'h32, "overrun");
    wr(`STATUS_OFS, 8'h30);
    i_far.send(8'h33, 0, 2'b00, 1'b1);
    rdchk(`STATUS_OFS, 8'h32, "overrun again unread");
    rdchk(`DATA_BUF_OFS, 8'h33, "newest kept");
    wr(`STATUS_OFS, 8'h10);
    i_far.send(8'h44, 0, 2'b00, 1'b1);
    rdchk(`STATUS_OFS, 8'h30, "no overrun after read");
    rdchk(`DATA_BUF_OFS, 8'h44, "fresh byte");
    wr(`STATUS_OFS, 8'h10);
  endtask

  task automatic t_multiproc;
    set_ctrl(8'h8D);
    rdchk(`RX_CTRL_OFS, 8'h8D, "address wait set");
    i_far.send(8'h77, 1, 2'b00, 1'b1);
    rdchk(`STATUS_OFS, 8'h10, "data frame ignored");
    rdchk(`DATA_BUF_OFS, 8'h44, "buffer untouched");
    i_far.send(8'h42, 1, 2'b01, 1'b1);
    rdchk(`STATUS_OFS, 8'h30, "address accepted");
    rdchk(`DATA_BUF_OFS, 8'h42, "address byte");
    wr(`STATUS_OFS, 8'h10);
    set_ctrl(8'h89);
    i_far.send(8'h99, 1, 2'b01, 1'b1);
    rdchk(`STATUS_OFS, 8'h38, "marker while data");
    rdchk(`DATA_BUF_OFS, 8'h99, "data wait byte");
    wr(`STATUS_OFS, 8'h00);
  endtask

  task automatic t_tx;
    logic [7:0] b;
    wr(`STATUS_OFS, 8'h40);
    wr(`DATA_BUF_OFS, 8'hC3);
    i_far.recv(b);
    chk({24'h000000, b}, 32'h000000C3, "tx byte");
    rdchk(`STATUS_OFS, 8'hC0, "tx ready flag");
    chk_pin(tx_irq, 1'b1, "tx_irq enabled");
    rdchk(`DATA_BUF_OFS, 8'h99, "rx side unchanged");
    wr(`STATUS_OFS, 8'h00);
    wr(`DATA_BUF_OFS, 8'h5A);
    i_far.recv(b);
    chk({24'h000000, b}, 32'h0000005A, "second tx byte");
    rdchk(`STATUS_OFS, 8'h80, "tx flag again");
    chk_pin(tx_irq, 1'b0, "tx_irq masked");
    set_ctrl(8'h9A);
    @(posedge hclk);
    chk_pin(sclk_oe, 1'b1, "sync master drives clock");
    set_ctrl(8'h98);
    @(posedge hclk);
    chk_pin(sclk_oe, 1'b0, "uart ignores master bit");
  endtask

  // Longest path is about 20 frames of 12 bits
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    bad_count       = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    haddr   = 32'h00000000;
    hwdata  = 32'h00000000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_basic();
    t_disabled();
    t_parity();
    t_framing();
    t_overrun();
    t_multiproc();
    t_tx();
    conclude();
  end
endmodule
`default_nettype wire
